//--- core/rswg_pkg.sv
// Operation
// - four byte registers at ports 72H to 75H, refresh count last
// - each general register holds separate memory and I/O counts
// - non-pipelined cycle inserts stored count plus one waits, 1 to 16
// - pipelined cycle inserts exactly the stored count, 0 to 15
// - refresh cycles use the 4-bit refresh wait count unless select is 11
// - select 11 during refresh keeps ready inactive, refresh count ignored
// - reset loads all ones into the three general registers
// - reading a general register returns the value last written; refresh reads low nibble only
// - 24-bit refresh address counter driven onto address bus in refresh
// - address advances by one for 8-bit, two for 16-bit refresh
// - reset clears the refresh address counter
// - enabled refresh: timer rising edge requests; disabled: pin shows timer
// - refresh strobe low once bus gained, released after cycle or reset
// - refresh has top priority, preempts DMA, DMA resumes afterwards
// - cascade acknowledge dropped, wait for request low, then refresh
// - already bus master: refresh without releasing or re-requesting bus
// - hold request, await acknowledge, strobe two clocks after acknowledge
// - refresh runs as memory read, ends on ready low, then drops hold
// - refresh lasts five bus states plus inserted wait states
// - memory/io flag and select pick register 0..2 half; 11 disables
// - upper nibble serves memory, lower nibble serves I/O accesses
// - select sampled on clock edge after last address strobe state
package rswg_pkg;

   localparam logic [7:0] RSWG_OFS_DLY0 = 8'h72;
   localparam logic [7:0] RSWG_OFS_DLY1 = 8'h73;
   localparam logic [7:0] RSWG_OFS_DLY2 = 8'h74;
   localparam logic [7:0] RSWG_OFS_REF = 8'h75;
   localparam int RSWG_NUM_DLY = 3;

   localparam logic [7:0] RSWG_DLY_RST = 8'hFF;
   localparam logic [3:0] RSWG_REF_DLY_RST = 4'h0;
   localparam logic [7:0] RSWG_RD_NONE = 8'h00;

   // nibble positions inside a general register
   localparam int RSWG_MEM_LSB = 4;
   localparam int RSWG_IO_LSB = 0;
   localparam int RSWG_NIB_W = 4;
   localparam logic [1:0] RSWG_SEL_OFF = 2'h3;

   // refresh strobe may go low no earlier than this after acknowledge
   localparam int RSWG_ACK_SETTLE = 2;
   localparam logic [1:0] RSWG_SETTLE_LAST = 2'(RSWG_ACK_SETTLE - 1);

   localparam int RSWG_ADDR_W = 24;
   localparam logic [23:0] RSWG_ADDR_RST = 24'h000000;
   localparam logic [23:0] RSWG_STEP8 = 24'h000001;
   localparam logic [23:0] RSWG_STEP16 = 24'h000002;

   typedef enum logic [4:0] {
      RSWG_IDLE = 5'h01,
      RSWG_RELEASE = 5'h02,
      RSWG_HOLD = 5'h04,
      RSWG_SETTLE = 5'h08,
      RSWG_STROBE = 5'h10
   } rswg_ref_state_t;

   typedef struct packed {
      logic sel;
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } rswg_reg_req_t;

   typedef struct packed {
      logic [23:0] addr;
      logic mem_read;
      logic strobe_n;
   } rswg_ref_bus_t;

endpackage

//--- core/rswg_delay_counter.sv
`timescale 1ns/10ps
module rswg_delay_counter #(
   parameter int W = 5
) (
   input wire logic core_clk, // system clock
   input wire logic rst_n, // async reset, active low
   input wire logic load, // start a new wait count
   input wire logic [W-1:0] load_val, // wait states to insert
   output logic done // pulse when the count has run out
);
   logic [W-1:0] cnt_ff;
   logic run_ff;
   logic done_ff;
   wire logic at_zero = (cnt_ff == '0);

   // count down one wait state per clock; a reload restarts cleanly
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_ff <= '0;
         run_ff <= 1'b0;
         done_ff <= 1'b0;
      end else begin
         done_ff <= run_ff & at_zero & !load;
         if (load) begin
            cnt_ff <= load_val;
            run_ff <= 1'b1;
         end else if (run_ff) begin
            run_ff <= !at_zero;
            cnt_ff <= at_zero ? cnt_ff : cnt_ff - W'(1);
         end
      end
   end

   assign done = done_ff;
endmodule

//--- core/rswg_top.sv
`timescale 1ns/10ps
module rswg_top
   import rswg_pkg::*;
(
   input wire logic core_clk, // system clock, 250 MHz
   input wire logic rst_n, // async hardware reset, active low
   input wire rswg_reg_req_t reg_req, // internal port access request
   output logic [7:0] reg_rdata, // port read data, registered
   input wire logic address_strobe_n, // host address strobe pin
   input wire logic [1:0] delay_select_inputs, // wait select pins
   input wire logic mem_io_sel, // 1 memory, 0 I/O cycle pin
   input wire logic pipelined_cycle, // current cycle is pipelined
   input wire logic bus_ready_n, // bus ready pin, active low
   output logic delay_gen_ready_out_n, // ready to host, active low
   input wire logic refresh_enable, // refresh feature on
   input wire logic refresh_bus_16, // 1 for 16-bit refresh bus
   input wire logic timer_one_output, // timer one output level
   output logic timer_one_refresh_pin, // shared timer/refresh pin
   input wire logic dma_cascade_grant, // DMA wants cascade granted
   input wire logic dma_channel_request, // cascaded request pin
   output logic cascade_acknowledge, // cascade acknowledge out
   input wire logic bus_master_now, // device already owns the bus
   output logic bus_hold_request, // hold request to host
   input wire logic bus_hold_acknowledge, // hold acknowledge pin
   output rswg_ref_bus_t ref_bus // refresh address and controls
);

   localparam int NPIN = 8;
   // resting levels: strobe and ready high, select 11 (generator off),
   // no request and no acknowledge, so reset fakes no pin event
   localparam logic [NPIN-1:0] PIN_IDLE = 8'hE4;

   // ---------------------------------------------------------------
   // pin synchronisers: stage one feeds stage two only
   // ---------------------------------------------------------------
   logic [NPIN-1:0] pin_meta_ff;
   logic [NPIN-1:0] pin_sync_ff;
   wire logic [NPIN-1:0] pin_raw = {address_strobe_n,
      delay_select_inputs, mem_io_sel, pipelined_cycle, bus_ready_n,
      dma_channel_request, bus_hold_acknowledge};

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_meta_ff <= PIN_IDLE; // idle levels of the pins
         pin_sync_ff <= PIN_IDLE;
      end else begin
         pin_meta_ff <= pin_raw;
         pin_sync_ff <= pin_meta_ff;
      end
   end

   wire logic ads_n_s = pin_sync_ff[7];
   wire logic [1:0] sel_s = pin_sync_ff[6:5];
   wire logic mem_s = pin_sync_ff[4];
   wire logic pipe_s = pin_sync_ff[3];
   wire logic rdy_n_s = pin_sync_ff[2];
   wire logic dreq_s = pin_sync_ff[1];
   wire logic bus_hold_acknowledge_s = pin_sync_ff[0];

   // ---------------------------------------------------------------
   // wait count registers
   // ---------------------------------------------------------------
   logic [7:0] dly_ff [RSWG_NUM_DLY];
   logic [3:0] ref_dly_ff;
   logic [7:0] rdata_ff;

   wire logic wr_go = reg_req.sel & reg_req.wr;
   wire logic rd_go = reg_req.sel & reg_req.rd;
   wire logic wr_ref = wr_go & (reg_req.addr == RSWG_OFS_REF);

   // one general register per entry, offsets follow each other
   genvar gi;
   generate
      for (gi = 0; gi < RSWG_NUM_DLY; gi++) begin : g_dly
         wire logic wr_me = wr_go &
            (reg_req.addr == RSWG_OFS_DLY0 + 8'(gi));
         always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
               dly_ff[gi] <= RSWG_DLY_RST;
            end else if (wr_me) begin
               dly_ff[gi] <= reg_req.wdata;
            end
         end
      end
   endgenerate

   // refresh count keeps only the low nibble
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ref_dly_ff <= RSWG_REF_DLY_RST;
      end else if (wr_ref) begin
         ref_dly_ff <= reg_req.wdata[3:0];
      end
   end

   // read-back mux; unused offsets answer zero
   logic [7:0] rd_val;
   always_comb begin
      rd_val = RSWG_RD_NONE;
      unique case (reg_req.addr)
         RSWG_OFS_DLY0: rd_val = dly_ff[0];
         RSWG_OFS_DLY1: rd_val = dly_ff[1];
         RSWG_OFS_DLY2: rd_val = dly_ff[2];
         RSWG_OFS_REF: rd_val = {4'h0, ref_dly_ff};
         default: rd_val = RSWG_RD_NONE;
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_ff <= RSWG_RD_NONE;
      end else begin
         rdata_ff <= rd_go ? rd_val : RSWG_RD_NONE;
      end
   end

   // ---------------------------------------------------------------
   // refresh request and arbitration
   // ---------------------------------------------------------------
   rswg_ref_state_t state_ff;
   rswg_ref_state_t nxt_state;
   logic timer_last_ff;
   logic pending_ff;
   logic [1:0] settle_ff;
   logic hold_ff;
   logic casc_ack_ff;
   logic pin_ff;
   logic [RSWG_ADDR_W-1:0] ref_addr_ff;
   rswg_ref_bus_t ref_bus_ff;

   wire logic timer_rise = timer_one_output & !timer_last_ff;
   wire logic ref_req = refresh_enable & timer_rise;
   wire logic in_strobe = (state_ff == RSWG_STROBE);
   // only a ready seen after the strobe is out ends the cycle
   wire logic ref_done = in_strobe & !ref_bus_ff.strobe_n &
      !rdy_n_s;
   wire logic settle_end = (settle_ff == RSWG_SETTLE_LAST);
   wire logic [RSWG_ADDR_W-1:0] ref_step =
      refresh_bus_16 ? RSWG_STEP16 : RSWG_STEP8;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         timer_last_ff <= 1'b0;
      end else begin
         timer_last_ff <= timer_one_output;
      end
   end

   // pending flag: a fresh timer edge outweighs the clear
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pending_ff <= 1'b0;
      end else if (ref_req) begin
         pending_ff <= 1'b1;
      end else if (ref_done) begin
         pending_ff <= 1'b0;
      end
   end

   // refresh sequencer; it starts ahead of any DMA grant. the acknowledge
   // and request pins arrive through the synchronisers, which costs two
   // clocks of reaction but keeps a metastable level out of the states
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         RSWG_IDLE: begin
            if (pending_ff) begin
               if (dma_cascade_grant) begin
                  nxt_state = RSWG_RELEASE;
               end else if (bus_master_now) begin
                  nxt_state = RSWG_STROBE;
               end else begin
                  nxt_state = RSWG_HOLD;
               end
            end
         end
         RSWG_RELEASE: begin
            // steal one cycle between DMA accesses
            if (!dreq_s && !casc_ack_ff) begin
               nxt_state = bus_master_now ? RSWG_STROBE
                  : RSWG_HOLD;
            end
         end
         RSWG_HOLD: begin
            if (bus_hold_acknowledge_s) begin
               nxt_state = RSWG_SETTLE;
            end
         end
         RSWG_SETTLE: begin
            if (settle_end) begin
               nxt_state = RSWG_STROBE;
            end
         end
         RSWG_STROBE: begin
            if (ref_done) begin
               nxt_state = RSWG_IDLE;
            end
         end
         default: nxt_state = RSWG_IDLE;
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= RSWG_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // clocks spent after the acknowledge before the strobe
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         settle_ff <= 2'h0;
      end else if (state_ff == RSWG_SETTLE) begin
         settle_ff <= settle_ff + 2'h1;
      end else begin
         settle_ff <= 2'h0;
      end
   end

   // hold is only raised when the bus must be won, kept to the end
   wire logic nxt_hold = (nxt_state == RSWG_HOLD) |
      (hold_ff & (nxt_state != RSWG_IDLE));

   // cascade grant withheld while refresh is pending or running
   wire logic nxt_casc = dma_cascade_grant & !pending_ff &
      (state_ff == RSWG_IDLE) & !ref_req;

   wire logic nxt_strobe_n = (nxt_state != RSWG_STROBE);

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         hold_ff <= 1'b0;
         casc_ack_ff <= 1'b0;
         pin_ff <= 1'b0;
      end else begin
         hold_ff <= nxt_hold;
         casc_ack_ff <= nxt_casc;
         pin_ff <= refresh_enable ? nxt_strobe_n
            : timer_one_output;
      end
   end

   // address counter steps once per finished refresh
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ref_addr_ff <= RSWG_ADDR_RST;
      end else if (ref_done) begin
         ref_addr_ff <= ref_addr_ff + ref_step;
      end
   end

   // refresh looks like a memory read on the bus; the address register
   // trails the counter by a clock, so the next address appears one clock
   // after the strobe rises, never while the strobe is low
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ref_bus_ff <= '{addr: RSWG_ADDR_RST, mem_read: 1'b0,
            strobe_n: 1'b1};
      end else begin
         ref_bus_ff.addr <= ref_addr_ff;
         ref_bus_ff.mem_read <= !nxt_strobe_n;
         ref_bus_ff.strobe_n <= nxt_strobe_n;
      end
   end

   // ---------------------------------------------------------------
   // wait state generator
   // ---------------------------------------------------------------
   logic ads_last_n_ff;
   logic ready_n_ff;
   logic cnt_done;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ads_last_n_ff <= 1'b1;
      end else begin
         ads_last_n_ff <= ads_n_s;
      end
   end

   // first edge after the strobe's last low state
   wire logic sel_take = !ads_last_n_ff & ads_n_s;
   wire logic gen_off = (sel_s == RSWG_SEL_OFF);
   wire logic ref_begin = (nxt_state == RSWG_STROBE) & !in_strobe;

   // choose register by select, then half by cycle type; select 11 has
   // no register, so it reads entry 0, never past the end of the array
   wire logic [1:0] sel_idx = gen_off ? 2'h0 : sel_s;
   wire logic [7:0] dly_sel = dly_ff[sel_idx];
   wire logic [3:0] nib = mem_s ?
      dly_sel[RSWG_MEM_LSB +: RSWG_NIB_W]
      : dly_sel[RSWG_IO_LSB +: RSWG_NIB_W];

   // pipelined cycles already gained a state, so no extra one
   wire logic [4:0] cpu_waits = {1'b0, nib} +
      {4'h0, !pipe_s};
   // the host bus supplies the five base states of a refresh; this block
   // only stretches it by the refresh count, with no extra state as for
   // CPU cycles, so a refresh lasts five plus that count
   wire logic [4:0] ref_waits = {1'b0, ref_dly_ff};

   // refresh cycles own the generator; CPU strobes are ignored then
   wire logic cpu_load = sel_take & !gen_off &
      (state_ff == RSWG_IDLE) & !ref_begin;
   wire logic ref_load = ref_begin & !gen_off;
   wire logic cnt_load = cpu_load | ref_load;
   wire logic [4:0] cnt_val = ref_load ? ref_waits
      : cpu_waits;

   // one shared down counter serves CPU and refresh cycles; the two loads
   // never meet, since a CPU load needs an idle sequencer and no refresh starting
   rswg_delay_counter #(
      .W(5)
   ) u_delay (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .load(cnt_load),
      .load_val(cnt_val),
      .done(cnt_done)
   );

   // one-cycle low ready ends the cycle after the counted waits
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ready_n_ff <= 1'b1;
      end else begin
         ready_n_ff <= !cnt_done;
      end
   end

   // ---------------------------------------------------------------
   // outputs, each straight from a flip-flop
   // ---------------------------------------------------------------
   assign reg_rdata = rdata_ff;
   assign delay_gen_ready_out_n = ready_n_ff;
   assign timer_one_refresh_pin = pin_ff;
   assign cascade_acknowledge = casc_ack_ff;
   assign bus_hold_request = hold_ff;
   assign ref_bus = ref_bus_ff;

endmodule

//--- sim/rswg_props.sv
`timescale 1ns/10ps
module rswg_props
   import rswg_pkg::*;
(
   input wire logic core_clk, // system clock
   input wire logic rst_n, // async reset, active low
   input wire logic delay_gen_ready_out_n, // ready out
   input wire logic refresh_enable, // refresh on
   input wire logic refresh_bus_16, // step size
   input wire logic timer_one_output, // timer level
   input wire logic timer_one_refresh_pin, // shared pin
   input wire logic dma_channel_request, // cascaded request
   input wire logic cascade_acknowledge, // cascade ack
   input wire logic bus_master_now, // device owns bus
   input wire logic bus_hold_request, // hold out
   input wire logic bus_hold_acknowledge, // hold ack in
   input wire rswg_ref_bus_t ref_bus // refresh bus
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   // refresh bus and handshake ordering
   chk_strobe_after_ack: assert property (
      $fell(ref_bus.strobe_n) && !bus_master_now
      |-> $past(bus_hold_acknowledge, 2)) else $error("strobe too early");
   chk_cascade_first: assert property (
      $fell(ref_bus.strobe_n) |-> !cascade_acknowledge && !dma_channel_request)
      else $error("cascade still on bus");
   chk_no_rerequest: assert property (
      bus_master_now && $past(bus_master_now) |-> !$rose(bus_hold_request))
      else $error("hold asked while master");
   chk_read_ctrl: assert property (
      !ref_bus.strobe_n |-> ref_bus.mem_read && $stable(ref_bus.addr))
      else $error("refresh read controls wrong");
   chk_addr_step: assert property (
      $rose(ref_bus.strobe_n) |=> ref_bus.addr == $past(ref_bus.addr)
      + ($past(refresh_bus_16, 2) ? RSWG_STEP16 : RSWG_STEP8))
      else $error("address step wrong");
   chk_hold_drop: assert property (
      $rose(ref_bus.strobe_n) |-> !bus_hold_request)
      else $error("hold kept after refresh");
   // shared pin: strobe when enabled, timer copy otherwise
   chk_pin_strobe: assert property (
      refresh_enable && $past(refresh_enable)
      |-> timer_one_refresh_pin == ref_bus.strobe_n) else $error("pin bad");
   chk_pin_timer: assert property (
      !refresh_enable && !$past(refresh_enable)
      |-> timer_one_refresh_pin == $past(timer_one_output))
      else $error("pin not timer");
   chk_ready_pulse: assert property (
      !delay_gen_ready_out_n |=> delay_gen_ready_out_n)
      else $error("ready longer than one cycle");
endmodule

bind rswg_top rswg_props i_props(.core_clk, .rst_n, .delay_gen_ready_out_n,
   .refresh_enable, .refresh_bus_16, .timer_one_output,
   .timer_one_refresh_pin, .dma_channel_request, .cascade_acknowledge,
   .bus_master_now, .bus_hold_request, .bus_hold_acknowledge, .ref_bus);

//--- sim/rswg_host_model.sv
`timescale 1ns/10ps
module rswg_host_model
   import rswg_pkg::*;
(
   input wire logic core_clk, // system clock
   input wire logic rst_n, // async reset, active low
   input wire logic slow, // answer late
   input wire logic bus_hold_request, // hold from device
   output logic bus_hold_acknowledge, // bus grant
   input wire rswg_ref_bus_t ref_bus, // refresh bus
   output logic bus_ready_n, // cycle end, pulled high
   input wire logic cascade_acknowledge, // cascade ack
   output logic dma_channel_request // cascaded request
);
   logic [4:0] cnt_ff;
   logic [1:0] casc_ff;
   wire [4:0] lim = slow ? 5'h14 : 5'h02;
   wire busy = (bus_hold_request && !bus_hold_acknowledge) || !ref_bus.strobe_n;

   // grant after a wait, end the read late or promptly
   // cascade drops its request a little after losing ack
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_ff <= 5'h00;
         casc_ff <= 2'h0;
         bus_hold_acknowledge <= 1'b0;
         bus_ready_n <= 1'b1;
         dma_channel_request <= 1'b0;
      end else begin
         cnt_ff <= busy ? cnt_ff + 5'h01 : 5'h00;
         bus_hold_acknowledge <= bus_hold_request &&
            (bus_hold_acknowledge || cnt_ff >= lim);
         bus_ready_n <= !(!ref_bus.strobe_n && cnt_ff >= lim);
         casc_ff <= {casc_ff[0], cascade_acknowledge};
         dma_channel_request <= casc_ff[1];
      end
   end
endmodule

//--- sim/rswg_top_bench.sv
`timescale 1ns/10ps
module rswg_top_bench
   import rswg_pkg::*;
;
   logic core_clk, rst_n = 1'b0, as_n = 1'b1, mio = 1'b0, pipe = 1'b0;
   logic ren = 1'b0, b16 = 1'b0, tmr = 1'b0, grant = 1'b0, own = 1'b0;
   logic slow = 1'b1;
   logic [1:0] sel = 2'h0;
   rswg_reg_req_t rq = '0;
   logic [7:0] rdata;
   logic rdy_o_n, pin, bus_ready_n, dma_channel_request, cascade_acknowledge;
   logic bus_hold_request, bus_hold_acknowledge;
   rswg_ref_bus_t rb;
   int error_cnt = 0, tests_run = 0, base, lat, p1, p2;
   // {mem, select, pipelined, expected waits}
   logic [8:0] wc [5] = '{9'h104, 9'h123, 9'h046, 9'h190, 9'h0A2};

   rswg_top i_dut(.core_clk, .rst_n, .reg_req(rq), .reg_rdata(rdata),
      .address_strobe_n(as_n), .delay_select_inputs(sel), .mem_io_sel(mio),
      .pipelined_cycle(pipe), .bus_ready_n, .delay_gen_ready_out_n(rdy_o_n),
      .refresh_enable(ren), .refresh_bus_16(b16), .timer_one_output(tmr),
      .timer_one_refresh_pin(pin), .dma_cascade_grant(grant),
      .dma_channel_request, .cascade_acknowledge, .bus_master_now(own),
      .bus_hold_request, .bus_hold_acknowledge, .ref_bus(rb));
   rswg_host_model i_host(.core_clk, .rst_n, .slow, .bus_hold_request,
      .bus_hold_acknowledge, .ref_bus(rb), .bus_ready_n,
      .cascade_acknowledge, .dma_channel_request);

   // 250 MHz clock
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end

   task automatic chk(input string nm, input logic [23:0] got,
                      input logic [23:0] exp);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic finish_test();
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // register port: one request cycle, data back the cycle after
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      rq <= '{1'b1, 1'b1, 1'b0, a, d};
      @(posedge core_clk);
      rq <= '0;
      @(posedge core_clk);
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      rq <= '{1'b1, 1'b0, 1'b1, a, 8'h00};
      @(posedge core_clk);
      rq <= '0;
      #1 chk("reg_rdata", 24'(rdata), 24'(e));
      @(posedge core_clk);
   endtask

   // host cycle: strobe one clock, count clocks to the ready pulse
   task automatic wcyc(input logic m, input logic [1:0] s, input logic p,
                       output int l);
      mio <= m;
      sel <= s;
      pipe <= p;
      as_n <= 1'b0;
      @(posedge core_clk);
      as_n <= 1'b1;
      l = 0;
      do begin
         @(posedge core_clk);
         #1 l++;
      end while (rdy_o_n !== 1'b0 && l < 60);
      repeat (3) @(posedge core_clk);
   endtask

   // timer edge starts a refresh; ps is where ready fell inside it
   task automatic refr(input logic [23:0] ea, output int ps);
      int t;
      t = 0;
      ps = 0;
      tmr <= 1'b1; // one timer expiry per refresh
      do begin
         @(posedge core_clk);
         #1 t++;
      end while (rb.strobe_n !== 1'b0 && t < 200);
      tmr <= 1'b0;
      chk("refresh_addr", rb.addr, ea);
      chk("refresh_pin", 24'(pin), 24'h000000);
      t = 0;
      while (rb.strobe_n !== 1'b1 && t < 200) begin
         if (rdy_o_n === 1'b0) ps = t;
         @(posedge core_clk);
         #1 t++;
      end
      repeat (4) @(posedge core_clk);
   endtask

   // whole run is a few hundred clocks
   initial begin
      repeat (20000) @(posedge core_clk);
      error_cnt++;
      finish_test();
   end

   initial begin
      repeat (10) @(posedge core_clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge core_clk);
      rd(8'h72, 8'hFF);
      rd(8'h73, 8'hFF);
      rd(8'h74, 8'hFF);
      rd(8'h75, 8'h00);
      wr(8'h72, 8'h30);
      wr(8'h73, 8'h05);
      wr(8'h74, 8'hF2);
      wr(8'h75, 8'hA2);
      wr(8'h76, 8'h55);
      rd(8'h72, 8'h30);
      rd(8'h73, 8'h05);
      rd(8'h74, 8'hF2);
      rd(8'h75, 8'h02);
      rd(8'h76, 8'h00);
      wcyc(1'b0, 2'h0, 1'b1, base);
      for (int i = 0; i < 5; i++) begin
         wcyc(wc[i][8], wc[i][7:6], wc[i][5], lat);
         chk("wait_states", 24'(lat - base), 24'(wc[i][4:0]));
      end
      wcyc(1'b1, 2'h3, 1'b0, lat);
      chk("wait_disabled", 24'(lat), 24'h00003C);
      // refresh with late ready so the refresh wait count shows
      sel <= 2'h0;
      ren <= 1'b1;
      @(posedge core_clk);
      refr(24'h000000, p1);
      wr(8'h75, 8'h06);
      refr(24'h000001, p2);
      chk("refresh_waits", 24'(p2 - p1), 24'h000004);
      b16 <= 1'b1;
      sel <= 2'h3;
      refr(24'h000002, p1);
      chk("refresh_ready_off", 24'(p1), 24'h000000);
      // prompt host, refresh steals a cycle from a cascaded transfer
      slow <= 1'b0;
      grant <= 1'b1;
      repeat (10) @(posedge core_clk);
      chk("cascade_on", 24'(cascade_acknowledge), 24'h000001);
      refr(24'h000004, p1);
      repeat (10) @(posedge core_clk);
      chk("cascade_back", 24'(cascade_acknowledge), 24'h000001);
      grant <= 1'b0;
      own <= 1'b1;
      repeat (4) @(posedge core_clk);
      refr(24'h000006, p1);
      chk("no_hold", 24'(bus_hold_request), 24'h000000);
      own <= 1'b0;
      ren <= 1'b0;
      repeat (3) @(posedge core_clk);
      tmr <= 1'b1;
      repeat (2) @(posedge core_clk);
      #1 chk("pin_timer", 24'(pin), 24'h000001);
      finish_test();
   end
endmodule
